/* File: rtl/pbsg_pkg.sv */
package pbsg_pkg;

  // Register port
  localparam int AW = 9;
  localparam int DW = 16;

  localparam logic [AW-1:0] OFS_PLANE0 = 9'h100;
  localparam logic [AW-1:0] OFS_HLEN = 9'h1C0;
  localparam logic [AW-1:0] OFS_HS_END = 9'h1C2;
  localparam logic [AW-1:0] OFS_HB_BEGIN = 9'h1C4;
  localparam logic [AW-1:0] OFS_HB_END = 9'h1C6;
  localparam logic [AW-1:0] OFS_VLEN = 9'h1C8;
  localparam logic [AW-1:0] OFS_VS_END = 9'h1CA;
  localparam logic [AW-1:0] OFS_VB_BEGIN = 9'h1CC;
  localparam logic [AW-1:0] OFS_VB_END = 9'h1CE;
  localparam logic [AW-1:0] OFS_BEAM_CTRL = 9'h1DC;
  localparam logic [AW-1:0] OFS_HS_BEGIN = 9'h1DE;
  localparam logic [AW-1:0] OFS_VS_BEGIN = 9'h1E0;
  localparam logic [AW-1:0] OFS_ILACE_POS = 9'h1E2;
  localparam logic [AW-1:0] OFS_WIN_HIGH = 9'h1E4;
  localparam logic [AW-1:0] OFS_WIN_START = 9'h1E6;
  localparam logic [AW-1:0] OFS_WIN_STOP = 9'h1E8;
  localparam logic [AW-1:0] OFS_VPOS_READ = 9'h1EA;
  localparam logic [AW-1:0] OFS_HPOS_READ = 9'h1EC;

  // Beam control fields, then the plane0 lace bit and window high-bit fields
  localparam int B_FIXED_BLANK_DIS = 14;
  localparam int B_LPEN_IGNORE = 13;
  localparam int B_PROG_VBLANK = 12;
  localparam int B_LOL_DIS = 11;
  localparam int B_PROG_VSYNC = 9;
  localparam int B_PROG_HSYNC = 8;
  localparam int B_PROG_TOTALS = 7;
  localparam int B_ULTRA_RES = 6;
  localparam int B_PAL = 5;
  localparam int B_CSYNC_POL = 2;
  localparam int B_VSYNC_POL = 1;
  localparam int B_HSYNC_POL = 0;
  localparam int B_LACE = 2;
  localparam int HI_HSTOP8 = 13;
  localparam int HI_HSTART8 = 5;
  localparam logic [15:0] BEAM_CTRL_RST = 16'h0000;

  // Hardwired timing
  localparam logic [8:0] FIX_HORIZONTAL_LINE_LENGTH = 9'h0E2;
  localparam logic [10:0] FIX_VERTICAL_FIELD_LENGTH_NTSC = 11'h106;
  localparam logic [10:0] FIX_VERTICAL_FIELD_LENGTH_PAL = 11'h138;
  localparam logic [7:0] FIX_HS_BEGIN = 8'h12;
  localparam logic [7:0] FIX_HS_END = 8'h23;
  localparam logic [10:0] FIX_VS_BEGIN = 11'h003;
  localparam logic [10:0] FIX_VS_END = 11'h006;
  localparam logic [8:0] FIX_HB_BEGIN = 9'h00F;
  localparam logic [8:0] FIX_HB_END = 9'h035;
  localparam logic [10:0] FIX_VB_END_NTSC = 11'h014;
  localparam logic [10:0] FIX_VB_END_PAL = 11'h019;

  // Colour clock step
  localparam int CCK_NS = 280;
  localparam int MCLK_NS = 50;
  localparam logic [2:0] CCK_DIV = 3'((CCK_NS + MCLK_NS - 1) / MCLK_NS);

endpackage

/* File: rtl/pbsg_span.sv */
`timescale 1ns/1ns
`default_nettype none
module pbsg_span import pbsg_pkg::*; #(
  parameter int W = 9
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Position compare
  input wire logic step,
  input wire logic [W-1:0] pos,
  input wire logic [W-1:0] begin_pos,
  input wire logic [W-1:0] end_pos,
  // Result
  output logic active
);

  typedef struct packed {
    logic act;
  } pbsg_span_s;

  pbsg_span_s s_r;
  pbsg_span_s s_nxt;

  // Begin is tested last so equal begin and end leaves it asserted
  always_comb begin
    s_nxt = s_r;
    if (step && pos == end_pos) begin
      s_nxt.act = 1'b0; // R25
    end
    if (step && pos == begin_pos) begin
      s_nxt.act = 1'b1; // R25
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign active = s_r.act;

endmodule // pbsg_span
`default_nettype wire

/* File: rtl/pbsg_top.sv */
// Functional notes
// R1 - Line length register counts 280ns steps; code steps every 6 mclk cycles, 300ns
// R2 - Vertical counter wraps at total; total+1 lines
// R3 - Interlace: long field total+2, short total+1
// R4 - Vertical sync between programmed begin/end lines
// R5 - Horizontal sync between programmed begin/end counts
// R6 - Alternate field vsync changes at centre position
// R7 - Blanking from four programmed begin/end positions
// R8 - Software places centre, blanks around sync
// R9 - Bit 14 drops hardwired blanking
// R10 - Bit 13 reads live vertical, ignores pen
// R11 - Bit 12 programmed vblank, no hard window stop
// R12 - Bit 11 stops long/short line alternation
// R13 - Bits 9/8 enable programmed vertical/horizontal sync
// R14 - Bit 7 lets programmed totals govern wrap
// R15 - Bit 6 ultra-resolution, bit 5 PAL timing
// R16 - Bits 2..0 set composite/vertical/horizontal polarity
// R17 - Software writes only supported beam modes
// R18 - Window registers: vertical high byte, horizontal low
// R19 - Legacy: start high bits zero, stop H8 one
// R20 - High-bits register bit 13 gives stop H8
// R21 - Bit 5 start H8, bits 10:8 stop V
// R22 - High bits apply only when written last
// R23 - Programmed totals only while totals enable set
// R24 - Horizontal wraps after total, then vertical advances
// R25 - Outputs held from begin match to end match
`timescale 1ns/1ns
`default_nettype none
module pbsg_top import pbsg_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [DW-1:0] rdata,
  // Light pen pin
  input wire logic lpen_n,
  // Monitor side
  output logic hsync,
  output logic vsync,
  output logic csync,
  output logic blank,
  output logic window,
  // Mode status
  output logic pal_mode,
  output logic ultra_res
);

  typedef struct packed {
    logic lp_s1;
    logic lp_s2;
    logic lp_prev;
    logic lp_held;
    logic [10:0] lp_v;
    logic [2:0] div;
    logic cck;
    logic [8:0] hcnt;
    logic [10:0] vcnt;
    logic lof;
    logic lol;
    logic [15:0] bc;
    logic [15:0] plane0;
    logic [15:0] win_start;
    logic [15:0] win_stop;
    logic [15:0] win_high;
    logic ext_ok;
    logic [7:0] hlen;
    logic [7:0] hsb;
    logic [7:0] hse;
    logic [7:0] hctr;
    logic [7:0] hbb;
    logic [7:0] hbe;
    logic [10:0] vlen;
    logic [10:0] vsb;
    logic [10:0] vse;
    logic [10:0] vbb;
    logic [10:0] vbe;
    logic [15:0] rdata;
    logic hsync_q;
    logic vsync_q;
    logic csync_q;
    logic blank_q;
    logic window_q;
  } pbsg_state_s;

  // Sync pins idle inactive for the default active-low polarity
  localparam pbsg_state_s S_RST = '{
    hsync_q: 1'b1, vsync_q: 1'b1, csync_q: 1'b1,
    bc: BEAM_CTRL_RST, default: 0};

  pbsg_state_s s_r;
  pbsg_state_s s_nxt;

  logic cck_last;
  logic lace;
  logic lol_extra;
  logic [8:0] htot_eff;
  logic [10:0] vtot_base;
  logic [10:0] vtot_eff;
  logic h_wrap;
  logic v_wrap;
  logic [7:0] hs_begin;
  logic [7:0] hs_end;
  logic [10:0] vs_begin;
  logic [10:0] vs_end;
  logic [8:0] vs_hpos;
  logic vs_step;
  logic vb_step;
  logic hs_act;
  logic vs_act;
  logic hb_prog;
  logic vb_prog;
  logic hard_hb;
  logic hard_vb;
  logic [10:0] vb_end_fix;
  logic hblank;
  logic vblank;
  logic [8:0] win_hstart;
  logic [8:0] win_hstop;
  logic [10:0] win_vstart;
  logic [10:0] win_vstop;
  logic win_on;
  logic [10:0] vread;

  assign cck_last = s_r.div == CCK_DIV - 3'h1; // R1
  assign lace = s_r.plane0[B_LACE];
  // Odd line lengths are approximated by alternating long lines
  assign lol_extra = s_r.lol & ~s_r.bc[B_LOL_DIS]
    & ~s_r.bc[B_PAL]; // R12
  assign htot_eff = (s_r.bc[B_PROG_TOTALS] ? {1'b0, s_r.hlen}
    : FIX_HORIZONTAL_LINE_LENGTH) + {8'h00, lol_extra}; // R1 R14 R23
  assign vtot_base = s_r.bc[B_PAL] ? FIX_VERTICAL_FIELD_LENGTH_PAL
    : FIX_VERTICAL_FIELD_LENGTH_NTSC; // R15
  assign vtot_eff = (s_r.bc[B_PROG_TOTALS] ? s_r.vlen : vtot_base)
    + {10'h000, lace & s_r.lof}; // R2 R3 R14 R23
  assign h_wrap = s_r.hcnt == htot_eff; // R24
  assign v_wrap = s_r.vcnt == vtot_eff; // R2

  assign hs_begin = s_r.bc[B_PROG_HSYNC] ? s_r.hsb
    : FIX_HS_BEGIN; // R13
  assign hs_end = s_r.bc[B_PROG_HSYNC] ? s_r.hse : FIX_HS_END; // R13
  assign vs_begin = s_r.bc[B_PROG_VSYNC] ? s_r.vsb
    : FIX_VS_BEGIN; // R13
  assign vs_end = s_r.bc[B_PROG_VSYNC] ? s_r.vse : FIX_VS_END; // R13
  assign vs_hpos = (lace & ~s_r.lof) ? {1'b0, s_r.hctr}
    : 9'h000; // R6
  assign vs_step = s_r.cck & (s_r.hcnt == vs_hpos);
  assign vb_step = s_r.cck & (s_r.hcnt == 9'h000);

  pbsg_span #(.W(9)) u_hsync (
    .mclk(mclk),
    .rstn(rstn),
    .step(s_r.cck),
    .pos(s_r.hcnt),
    .begin_pos({1'b0, hs_begin}),
    .end_pos({1'b0, hs_end}),
    .active(hs_act)
  ); // R5

  pbsg_span #(.W(11)) u_vsync (
    .mclk(mclk),
    .rstn(rstn),
    .step(vs_step),
    .pos(s_r.vcnt),
    .begin_pos(vs_begin),
    .end_pos(vs_end),
    .active(vs_act)
  ); // R4

  pbsg_span #(.W(9)) u_hblank (
    .mclk(mclk),
    .rstn(rstn),
    .step(s_r.cck),
    .pos(s_r.hcnt),
    .begin_pos({1'b0, s_r.hbb}),
    .end_pos({1'b0, s_r.hbe}),
    .active(hb_prog)
  ); // R7

  pbsg_span #(.W(11)) u_vblank (
    .mclk(mclk),
    .rstn(rstn),
    .step(vb_step),
    .pos(s_r.vcnt),
    .begin_pos(s_r.vbb),
    .end_pos(s_r.vbe),
    .active(vb_prog)
  ); // R7

  assign vb_end_fix = s_r.bc[B_PAL] ? FIX_VB_END_PAL : FIX_VB_END_NTSC;
  assign hard_hb = (s_r.hcnt >= FIX_HB_BEGIN)
    && (s_r.hcnt < FIX_HB_END);
  assign hard_vb = s_r.vcnt < vb_end_fix;
  assign hblank = hb_prog
    | (~s_r.bc[B_FIXED_BLANK_DIS] & hard_hb); // R7 R9
  assign vblank = (s_r.bc[B_PROG_VBLANK] & vb_prog)
    | (~s_r.bc[B_FIXED_BLANK_DIS] & hard_vb); // R9 R11

  // Extension bits count only when written after start and stop
  assign win_hstart = {s_r.ext_ok & s_r.win_high[HI_HSTART8],
    s_r.win_start[7:0]}; // R18 R19 R21
  assign win_hstop = {~s_r.ext_ok | s_r.win_high[HI_HSTOP8],
    s_r.win_stop[7:0]}; // R19 R20
  assign win_vstart = {s_r.ext_ok ? s_r.win_high[2:0] : 3'b000,
    s_r.win_start[15:8]}; // R18 R19 R21
  assign win_vstop = {s_r.ext_ok ? s_r.win_high[10:8]
    : {2'b00, ~s_r.win_stop[15]}, s_r.win_stop[15:8]}; // R21 R22
  assign win_on = (s_r.hcnt >= win_hstart) && (s_r.hcnt < win_hstop)
    && (s_r.vcnt >= win_vstart) && (s_r.vcnt < win_vstop)
    && (s_r.bc[B_PROG_VBLANK] | ~hard_vb); // R11

  assign vread = (s_r.bc[B_LPEN_IGNORE] | ~s_r.lp_held) ? s_r.vcnt
    : s_r.lp_v; // R10

  always_comb begin
    s_nxt = s_r;
    s_nxt.lp_s1 = lpen_n;
    s_nxt.lp_s2 = s_r.lp_s1;
    s_nxt.lp_prev = s_r.lp_s2;
    s_nxt.rdata = '0;
    s_nxt.div = cck_last ? 3'h0 : s_r.div + 3'h1;
    s_nxt.cck = cck_last;
    if (s_r.cck) begin
      if (h_wrap) begin
        s_nxt.hcnt = 9'h000; // R24
        s_nxt.lol = ~s_r.lol & ~s_r.bc[B_LOL_DIS]; // R12
        if (v_wrap) begin
          s_nxt.vcnt = 11'h000; // R2
          s_nxt.lof = lace ? ~s_r.lof : 1'b1; // R3
          s_nxt.lp_held = 1'b0;
        end else begin
          s_nxt.vcnt = s_r.vcnt + 11'h001; // R24
        end
      end else begin
        s_nxt.hcnt = s_r.hcnt + 9'h001; // R24
      end
    end
    // Pen latch after the field clear so a coincident hit is kept
    if (s_r.lp_prev && !s_r.lp_s2 && !s_r.lp_held) begin
      s_nxt.lp_held = 1'b1;
      s_nxt.lp_v = s_r.vcnt;
    end
    if (wr_stb) begin
      case (addr)
        OFS_PLANE0: s_nxt.plane0 = wdata;
        OFS_HLEN: s_nxt.hlen = wdata[7:0];
        OFS_HS_END: s_nxt.hse = wdata[7:0];
        OFS_HB_BEGIN: s_nxt.hbb = wdata[7:0];
        OFS_HB_END: s_nxt.hbe = wdata[7:0];
        OFS_VLEN: s_nxt.vlen = wdata[10:0];
        OFS_VS_END: s_nxt.vse = wdata[10:0];
        OFS_VB_BEGIN: s_nxt.vbb = wdata[10:0];
        OFS_VB_END: s_nxt.vbe = wdata[10:0];
        OFS_BEAM_CTRL: s_nxt.bc = wdata;
        OFS_HS_BEGIN: s_nxt.hsb = wdata[7:0];
        OFS_VS_BEGIN: s_nxt.vsb = wdata[10:0];
        OFS_ILACE_POS: s_nxt.hctr = wdata[7:0];
        OFS_WIN_HIGH: begin
          s_nxt.win_high = wdata;
          s_nxt.ext_ok = 1'b1; // R22
        end
        OFS_WIN_START: begin
          s_nxt.win_start = wdata; // R18
          s_nxt.ext_ok = 1'b0; // R22
        end
        OFS_WIN_STOP: begin
          s_nxt.win_stop = wdata; // R18
          s_nxt.ext_ok = 1'b0; // R22
        end
        default: s_nxt.ext_ok = s_r.ext_ok;
      endcase
    end
    if (rd_stb) begin
      case (addr)
        OFS_VPOS_READ: s_nxt.rdata = {s_r.lof, 4'h0, vread}; // R10
        OFS_HPOS_READ: s_nxt.rdata = {7'h00, s_r.hcnt};
        default: s_nxt.rdata = 16'h0000;
      endcase
    end
    s_nxt.hsync_q = ~(hs_act ^ s_r.bc[B_HSYNC_POL]); // R16
    s_nxt.vsync_q = ~(vs_act ^ s_r.bc[B_VSYNC_POL]); // R16
    s_nxt.csync_q = ~((hs_act ^ vs_act) ^ s_r.bc[B_CSYNC_POL]); // R16
    s_nxt.blank_q = hblank | vblank; // R7
    s_nxt.window_q = win_on & ~(hblank | vblank);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign hsync = s_r.hsync_q;
  assign vsync = s_r.vsync_q;
  assign csync = s_r.csync_q;
  assign blank = s_r.blank_q;
  assign window = s_r.window_q;
  assign pal_mode = s_r.bc[B_PAL]; // R15
  assign ultra_res = s_r.bc[B_ULTRA_RES]; // R15

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_hwrap;
    s_r.cck && h_wrap |=> s_r.hcnt == 9'h000 && !s_r.cck;
  endproperty
  a_hwrap: assert property (p_hwrap) // R24
    else $error("horizontal counter did not wrap");

  property p_vwrap;
    s_r.cck && h_wrap && v_wrap |=> s_r.vcnt == 11'h000;
  endproperty
  a_vwrap: assert property (p_vwrap) // R2
    else $error("vertical counter did not wrap");

  property p_long_field;
    s_r.cck && h_wrap && lace && s_r.lof
      && s_r.vcnt == (s_r.bc[B_PROG_TOTALS] ? s_r.vlen : vtot_base)
      |=> s_r.vcnt == $past(s_r.vcnt) + 11'h001;
  endproperty
  a_long_field: assert property (p_long_field) // R3
    else $error("long field ended one line early");

  property p_fixed_len;
    !s_r.bc[B_PROG_TOTALS] |-> s_r.hcnt <= FIX_HORIZONTAL_LINE_LENGTH + 9'h001;
  endproperty
  a_fixed_len: assert property (p_fixed_len) // R23
    else $error("line exceeded hardwired length");

  property p_hs_begin;
    s_r.cck && s_r.hcnt == {1'b0, hs_begin} |=> hs_act;
  endproperty
  a_hs_begin: assert property (p_hs_begin) // R5
    else $error("horizontal sync not asserted at begin");

  property p_hs_pin;
    s_r.bc[B_HSYNC_POL] && $stable(s_r.bc) |=> hsync == $past(hs_act);
  endproperty
  a_hs_pin: assert property (p_hs_pin) // R16
    else $error("horizontal sync pin polarity wrong");

  property p_live_read;
    rd_stb && addr == OFS_VPOS_READ && s_r.bc[B_LPEN_IGNORE]
      |=> rdata[10:0] == $past(s_r.vcnt);
  endproperty
  a_live_read: assert property (p_live_read) // R10
    else $error("vertical read not live");

  property p_no_hard_blank;
    s_r.bc[B_FIXED_BLANK_DIS] && !hb_prog && !s_r.bc[B_PROG_VBLANK]
      |-> !hblank && !vblank;
  endproperty
  a_no_hard_blank: assert property (p_no_hard_blank) // R9
    else $error("hardwired blank still active");

  property p_legacy_bits;
    !s_r.ext_ok |-> win_hstop[8] && win_vstart[10:8] == 3'b000
      && !win_hstart[8];
  endproperty
  a_legacy_bits: assert property (p_legacy_bits) // R19
    else $error("legacy window high bits wrong");

  property p_ext_write;
    wr_stb && addr == OFS_WIN_HIGH |=> s_r.ext_ok
      && win_hstop[8] == $past(wdata[HI_HSTOP8]);
  endproperty
  a_ext_write: assert property (p_ext_write) // R20 R22
    else $error("window high bits not applied");

  c_field_wrap: cover property (s_r.cck && h_wrap && v_wrap);
  c_lace_short: cover property (lace && !s_r.lof && vs_step);
  c_window: cover property (s_r.ext_ok && window);
  c_pen: cover property (s_r.lp_held && rd_stb);

endmodule // pbsg_top
`default_nettype wire

/* File: verif/pbsg_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module pbsg_monitor (
  // Clock
  input wire logic mclk,
  // Pins from the generator
  input wire logic hsync,
  input wire logic vsync,
  input wire logic blank,
  // Measurements in mclk cycles; vs_cnt counts vsync rising edges
  output logic [15:0] hs_per,
  output logic [15:0] hs_hi,
  output logic [15:0] vs_per,
  output logic [15:0] vs_prev,
  output logic [15:0] vs_hi,
  output logic [15:0] bl_hi,
  output logic [15:0] vs_cnt
);
  // Differences of a wrapping timestamp stay exact below 65536 cycles
  logic [15:0] t = 16'h0000;
  logic [15:0] hs_t = 16'h0000;
  logic [15:0] vs_t = 16'h0000;
  logic [15:0] bl_t = 16'h0000;
  logic [15:0] cnt = 16'h0000;
  logic hs_q = 1'b1;
  logic vs_q = 1'b1;
  logic bl_q = 1'b0;

  assign vs_cnt = cnt;

  // A monitor only listens; it measures edge to edge
  always @(posedge mclk) begin
    t <= t + 16'h0001;
    hs_q <= hsync;
    vs_q <= vsync;
    bl_q <= blank;
    if (hsync && !hs_q) begin
      hs_per <= t - hs_t;
      hs_t <= t;
    end
    if (!hsync && hs_q) hs_hi <= t - hs_t;
    if (vsync && !vs_q) begin
      vs_prev <= vs_per;
      vs_per <= t - vs_t;
      vs_t <= t;
      cnt <= cnt + 16'h0001;
    end
    if (!vsync && vs_q) vs_hi <= t - vs_t;
    if (blank && !bl_q) bl_t <= t;
    if (!blank && bl_q) bl_hi <= t - bl_t;
  end
endmodule // pbsg_monitor
`default_nettype wire

/* File: verif/pbsg_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module pbsg_top_tb_top import pbsg_pkg::*;;
  logic mclk, rstn, wr_stb, rd_stb, lpen_n;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, d;
  logic hsync, vsync, csync, blank, window, pal_mode, ultra_res;
  logic [15:0] hs_per, hs_hi, vs_per, vs_prev, vs_hi, bl_hi, vs_cnt;
  int n_errors, checks_done, h, hsb, hse, k;
  logic [AW-1:0] wo[6] = '{OFS_BEAM_CTRL, OFS_WIN_START, OFS_WIN_STOP,
                          OFS_WIN_HIGH, OFS_HLEN, 9'h0F0};

  pbsg_top dut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .lpen_n(lpen_n),
    .hsync(hsync), .vsync(vsync), .csync(csync), .blank(blank),
    .window(window), .pal_mode(pal_mode), .ultra_res(ultra_res));

  pbsg_monitor mon (.mclk(mclk), .hsync(hsync), .vsync(vsync),
    .blank(blank), .hs_per(hs_per), .hs_hi(hs_hi), .vs_per(vs_per),
    .vs_prev(vs_prev), .vs_hi(vs_hi), .bl_hi(bl_hi), .vs_cnt(vs_cnt));

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  task automatic give_verdict();
    $display("checks_done %0d n_errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [15:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a, output logic [15:0] v);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(negedge mclk);
    v = rdata;
  endtask

  task automatic settle(input int n);
    logic [15:0] c0;
    int i;
    c0 = vs_cnt;
    for (i = 0; i < 30000 && int'(vs_cnt - c0) < n; i++) @(posedge mclk);
    if (i == 30000) begin
      n_errors++;
      $display("BAD field count expected %0d seen %0d", n, vs_cnt - c0);
      give_verdict();
    end
  endtask

  // Window is periodic per field, so one field of cycles counts it exactly
  task automatic win_cycles(input logic [15:0] ex);
    int c;
    c = 0;
    settle(2);
    repeat (int'(cyc(60))) begin
      @(negedge mclk);
      c += int'(window);
    end
    chk("window cycles", ex, 16'(c));
  endtask

  function automatic logic [15:0] cyc(input int steps);
    return 16'(steps * CCK_DIV);
  endfunction

  // Field is fixed at six lines, vsync on lines 1 to 3, hblank 6 to 8
  task automatic line(input int ht, input int sb, input int se,
                      input logic [15:0] bc);
    int e;
    wr(OFS_HLEN, 16'(ht));
    wr(OFS_HS_BEGIN, 16'(sb));
    wr(OFS_HS_END, 16'(se));
    wr(OFS_BEAM_CTRL, bc);
    settle(3);
    chk("line period", cyc(ht + 1), hs_per);
    chk("hsync high", bc[0] ? cyc(se - sb) : cyc(ht + 1 - se + sb), hs_hi);
    chk("field period", cyc(6 * (ht + 1)), vs_per);
    chk("vsync width", cyc(2 * (ht + 1)), vs_hi);
    chk("hblank width", cyc(2), bl_hi);
    e = 0;
    repeat (int'(cyc(6 * (ht + 1)))) begin
      @(negedge mclk);
      if (csync !== ((hsync ~^ bc[0]) ^ (vsync ~^ bc[1]) ~^ bc[2])) e++;
    end
    chk("csync cycles off", 16'h0000, 16'(e));
    rd(OFS_HPOS_READ, d);
    chk("hpos in line", 16'h0001, 16'(d <= 16'(ht)));
    rd(OFS_VPOS_READ, d);
    chk("vpos live", 16'h0001, 16'(d[10:0] <= 11'h005 && d[14:11] == 0));
    $display("test line %0d sync %0d..%0d done", ht, sb, se);
  endtask

  initial begin
    addr = '0;
    wdata = '0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    lpen_n = 1'b1;
    rstn = 1'b0;
    n_errors = 0;
    checks_done = 0;
    k = int'($urandom(32'hD530));
    @(posedge mclk);
    #1;
    chk("reset pins", 16'h0070, 16'({hsync, vsync, csync, blank, window,
        pal_mode, ultra_res}));
    @(posedge mclk);
    rstn <= 1'b1;
    $display("test reset done");
    // Write-only and unmapped places read back as zero
    foreach (wo[i]) begin
      rd(wo[i], d);
      chk("write-only read", 16'h0000, d);
    end
    $display("test register reads done");
    wr(OFS_VLEN, 16'h0005);
    wr(OFS_VS_BEGIN, 16'h0001);
    wr(OFS_VS_END, 16'h0003);
    wr(OFS_HB_BEGIN, 16'h0006);
    wr(OFS_HB_END, 16'h0008);
    wr(OFS_ILACE_POS, 16'h0000);
    line(9, 2, 4, 16'h6B83);
    line(9, 2, 4, 16'h6B82);
    line(9, 1, 8, 16'h6B83);
    for (k = 0; k < 4; k++) begin
      h = 9 + int'($urandom % 12);
      hsb = 1 + int'($urandom % (h - 3));
      hse = hsb + 1 + int'($urandom % 2);
      line(h, hsb, hse, 16'h6B83);
    end
    line(9, 2, 4, 16'h6B83);
    // Centre half a line after sync begin, blank from line start to one step past sync end
    wr(OFS_ILACE_POS, 16'h0007);
    wr(OFS_HB_BEGIN, 16'h0000);
    wr(OFS_HB_END, 16'h0005);
    wr(OFS_PLANE0, 16'h0004);
    settle(3);
    chk("long plus short", cyc(130), vs_per + vs_prev);
    chk("long to short", cyc(77), vs_per > vs_prev ? vs_per : vs_prev);
    // Lace goes off on line 1, below the programmed total
    wr(OFS_PLANE0, 16'h0000);
    $display("test interlace done");
    wr(OFS_VB_BEGIN, 16'h0004);
    wr(OFS_VB_END, 16'h0005);
    wr(OFS_WIN_START, 16'h0103);
    wr(OFS_WIN_STOP, 16'h0409);
    wr(OFS_BEAM_CTRL, 16'h7B83);
    win_cycles(16'h0060);
    wr(OFS_WIN_HIGH, 16'h0000);
    win_cycles(16'h0036);
    $display("test window done");
    // Pen hit on line 1, read back on line 2
    settle(1);
    lpen_n <= 1'b0;
    repeat (4) @(posedge mclk);
    lpen_n <= 1'b1;
    wr(OFS_BEAM_CTRL, 16'h5B83);
    repeat (60) @(posedge mclk);
    rd(OFS_VPOS_READ, d);
    chk("pen vpos", 16'h8001, d);
    wr(OFS_BEAM_CTRL, 16'h7B83);
    rd(OFS_VPOS_READ, d);
    chk("live vpos", 16'h0001, 16'(d[10:0] > 11'h001));
    $display("test pen done");
    for (k = 0; k < 4; k++) begin
      wr(OFS_BEAM_CTRL, 16'h6B83 | 16'(k << 5));
      @(negedge mclk);
      chk("mode status", 16'(k), 16'({ultra_res, pal_mode}));
    end
    $display("test mode bits done");
    give_verdict();
  end
endmodule // pbsg_top_tb_top
`default_nettype wire
